// >>> dv/tb_top.sv
// Self-checking random testbench of the timer burst-access window.
`timescale 1ns/10ps
module tb_top;
	logic clock, rst_n, read, write, waitrequest;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, q, d, c;
	logic [31:0] mem [18];
	int error_cnt, checked, cycles, seed, base, len, i, t, k;

	tdbw_window dut_u (.clock(clock), .rst_n(rst_n), .avs_address(address),
		.avs_read(read), .avs_write(write), .avs_byteenable(byteenable),
		.avs_writedata(writedata), .avs_readdata(readdata),
		.avs_waitrequest(waitrequest));
	tdbw_dma_model dma_u (.clock(clock), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest));

	// Clock of 8 ns period.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// A hang is cut short after far more cycles than the run needs.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			error_cnt++;
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Store word after a write with the given lanes.
	function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
		logic [3:0] be);
		for (int b = 0; b < 4; b++)
			if (be[b]) o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction

	// Expected window read: words past the store read zero.
	function automatic logic [31:0] word_at(int w);
		return (w < 18) ? mem[w] : 32'h0000_0000;
	endfunction

	// Window access j of a burst; the target wraps after len+1 accesses.
	task automatic win(input logic rd, input int j);
		k = base + (j % (len + 1));
		d = $random(seed);
		dma_u.dma(j[0], rd, d, q);
		if (rd)
			check("window read", q, word_at(k));
		else if (k < 18)
			mem[k] = merge(mem[k], d, j[0] ? 4'h3 : 4'h1);
	endtask

	// Main sequence: reset, fixed corners, then random bursts.
	initial begin
		seed = 32'h42d43f0e;
		rst_n = 1'b0;
		foreach (mem[w]) mem[w] = 32'h0000_0000;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		dma_u.xfer(1'b1, 8'h48, 4'h0, 32'h0, q);
		check("control reset", q, 32'h0000_0000);
		dma_u.xfer(1'b1, 8'h4C, 4'h0, 32'h0, q);
		check("window reset", q, 32'h0000_0000);
		dma_u.xfer(1'b0, 8'h54, 4'hF, 32'hFFFF_FFFF, q);
		dma_u.xfer(1'b1, 8'h54, 4'h0, 32'h0, q);
		check("unmapped", q, 32'h0000_0000);
		$display("test reset done");
		for (t = 0; t < 12; t++) begin
			base = (t < 2) ? t : $unsigned($random(seed)) % 18;
			len = (t == 0) ? 17 : (t == 1) ? 0 : $unsigned($random(seed)) % 18;
			c = {19'h0, len[4:0], 3'h0, base[4:0]};
			d = $random(seed);
			dma_u.xfer(1'b0, 8'h48, 4'hF, (d & 32'hFFFF_E0E0) | c, q);
			dma_u.xfer(1'b1, 8'h48, 4'h0, 32'h0, q);
			check("control", q, c);
			for (i = 0; i < len + 2; i++) win(1'b0, i);
			dma_u.xfer(1'b1, 8'h50, 4'h0, 32'h0, q);
			check("index", q, 32'(1 % (len + 1)));
			dma_u.xfer(1'b0, 8'h48, 4'hF, c, q);
			for (i = 0; i < len + 1; i++) win(1'b1, i);
			for (i = 0; i < 18; i++) begin
				dma_u.xfer(1'b1, 8'(4 * i), 4'h0, 32'h0, q);
				check("store", q, mem[i]);
			end
			$display("test burst %0d base %0d length %0d done", t, base, len);
		end
		test_done();
	end
endmodule

// >>> dv/tdbw_dma_model.sv
// Behavioural DMA master that drives the Avalon-MM port of the window.
`timescale 1ns/10ps
module tdbw_dma_model (
	input wire logic clock, // System clock.
	output logic [7:0] address, // Byte address.
	output logic read, // Read request.
	output logic write, // Write request.
	output logic [3:0] byteenable, // Byte lanes.
	output logic [31:0] writedata, // Write data.
	input wire logic [31:0] readdata, // Read data.
	input wire logic waitrequest // Stall from the slave.
);
	// Idle bus from time zero.
	initial begin
		{read, write, address, byteenable, writedata} = '0;
	end

	// Holds the request until an edge sees waitrequest low; no cycle count.
	task automatic xfer(input logic rd, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
		address <= a;
		read <= rd;
		write <= !rd;
		byteenable <= be;
		writedata <= d;
		// Waitrequest and read data are taken at the edge itself, before
		// the slave's registers move on that edge.
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask

	// Window transfer of 16-bit or 8-bit size.
	task automatic dma(input logic sz16, input logic rd, input logic [31:0] d,
		output logic [31:0] q);
		xfer(rd, 8'h4C, sz16 ? 4'h3 : 4'h1, d, q);
	endtask
endmodule

// >>> src/tdbw_mem_if.sv
// Interface between the window logic and the timer register store.
`timescale 1ns/10ps
interface tdbw_mem_if;
	logic [5:0] addr;
	logic we;
	logic [3:0] be;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport ctrl (output addr, output we, output be, output wdata,
		input rdata);
	modport store (input addr, input we, input be, input wdata,
		output rdata);
endinterface

// >>> src/tdbw_pkg.sv
// Package with the constants and types of the timer burst-access window.
// Summary of operation
// RULE_01: A 5-bit base offset picks the first timer register of a burst, counted in words from control register one.
// RULE_02: A 5-bit burst length plus one gives the number of transfers in a burst, so zero means one and 10001 means eighteen.
// RULE_03: Each access to the window register is redirected to word (base offset + burst index) above control register one.
// RULE_04: The burst index advances by one with every access to the window register, over the programmed number of transfers.
// RULE_05: The DMA may use 8-bit or 16-bit transfers, and either way the same number of timer registers is reached.
// RULE_06: After reset the burst control register at 0x48 and the window register at 0x4C both read as zero.
// RULE_07: The burst index returns to zero after the last transfer of a burst or when burst control is written.
package tdbw_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int IDX_W = 6;
	localparam int FIELD_W = 5;

	// Byte offsets of the registers on the bus.
	localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
	localparam logic [7:0] BURST_CTRL_OFFSET = 8'h48;
	localparam logic [7:0] BURST_WINDOW_OFFSET = 8'h4C;
	localparam logic [7:0] BURST_STATUS_OFFSET = 8'h50;

	// Number of timer register words that sit below burst control.
	localparam logic [5:0] TIMER_WORDS = 6'h12;

	// Field layout of burst control.
	localparam int BASE_LSB = 0;
	localparam int LEN_LSB = 8;

	// Reset values.
	localparam logic [15:0] BURST_CTRL_RESET = 16'h0000;
	localparam logic [31:0] BURST_WINDOW_RESET = 32'h0000_0000;
	localparam logic [4:0] FIELD_RESET = 5'h00;

	// Sequencer states of the bus slave, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_DONE = 3'b100
	} tdbw_state_t;

endpackage

// >>> src/tdbw_regs.sv
// Timer register store reached directly and through the burst window.
`timescale 1ns/10ps
module tdbw_regs (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	tdbw_mem_if.store port // Word access from the window logic.
);

	logic [31:0] words [0:17];
	logic [31:0] rdataReg;
	logic inRange;

	// Words above the store read as zero and swallow writes.
	assign inRange = port.addr < tdbw_pkg::TIMER_WORDS;

	// Each word clears on reset and takes writes on every enabled byte lane in the same cycle.
	for (genvar w = 0; w < 18; w++) begin : g_word
		for (genvar b = 0; b < 4; b++) begin : g_lane
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					words[w][8*b +: 8] <= 8'h00;
				end else if (port.we && inRange && port.be[b] &&
					port.addr == 6'(w)) begin
					words[w][8*b +: 8] <= port.wdata[8*b +: 8];
				end
			end
		end
	end

	// Read data come from a register, one cycle after the address.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdataReg <= tdbw_pkg::BURST_WINDOW_RESET;
		end else begin
			rdataReg <= inRange ? words[port.addr[4:0]] : 32'h0000_0000;
		end
	end

	assign port.rdata = rdataReg;

endmodule

// >>> src/tdbw_window.sv
// Avalon-MM register bank with the DMA burst-access window of the timer.
`timescale 1ns/10ps
module tdbw_window (
	input wire logic clock, // System clock, 125 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [7:0] avs_address, // Byte address of the request.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [3:0] avs_byteenable, // Byte lanes of a write.
	input wire logic [31:0] avs_writedata, // Write data.
	output logic [31:0] avs_readdata, // Read data, from a register.
	output logic avs_waitrequest // Stall, low when answered.
);

	// Word index of a byte address; used for requests and fixed offsets.
	function automatic logic [5:0] wordIndex(input logic [7:0] a);
		return a[7:2];
	endfunction

	localparam logic [5:0] CTRL_IDX =
		wordIndex(tdbw_pkg::BURST_CTRL_OFFSET);
	localparam logic [5:0] WIN_IDX =
		wordIndex(tdbw_pkg::BURST_WINDOW_OFFSET);
	localparam logic [5:0] STAT_IDX =
		wordIndex(tdbw_pkg::BURST_STATUS_OFFSET);
	localparam logic [5:0] ONE_IDX =
		wordIndex(tdbw_pkg::CTRL_ONE_OFFSET);

	tdbw_mem_if memBus ();

	tdbw_regs uStore (
		.clock(clock),
		.rst_n(rst_n),
		.port(memBus.store)
	);

	tdbw_pkg::tdbw_state_t stateReg, stateNext;
	logic [4:0] baseReg, baseNext;
	logic [4:0] lenReg, lenNext;
	logic [4:0] idxReg, idxNext;
	logic [5:0] tgtReg;
	logic winReg;
	logic [31:0] readDataReg;

	wire req = avs_read | avs_write;
	wire stIdle = stateReg == tdbw_pkg::ST_IDLE;
	wire stFetch = stateReg == tdbw_pkg::ST_FETCH;
	wire stDone = stateReg == tdbw_pkg::ST_DONE;

	// Address decode of the incoming request.
	wire [5:0] reqIdx = wordIndex(avs_address);
	wire hitWin = reqIdx == WIN_IDX;

	// Window target: control register one plus base plus index, in words.
	// Six bits hold the largest sum, 31 + 31, so nothing wraps.
	wire [5:0] winIdx = ONE_IDX + {1'b0, baseReg} + {1'b0, idxReg}; // [RULE_01] [RULE_03]
	wire [5:0] tgtIdx = hitWin ? winIdx : reqIdx; // [RULE_03]

	// Latched decode used in the later cycles of the access.
	wire tgtCtrl = !winReg && tgtReg == CTRL_IDX;
	wire tgtStat = !winReg && tgtReg == STAT_IDX;
	wire tgtStore = tgtReg < tdbw_pkg::TIMER_WORDS;
	wire doneWr = stDone && avs_write;
	wire ctrlWr = doneWr && tgtCtrl;
	wire winDone = stDone && winReg;

	// Register images; reserved bits read as zero.
	wire [31:0] ctrlWord = {16'h0000, 3'b000, lenReg, 3'b000, baseReg};
	wire [31:0] statWord = {27'h000_0000, idxReg};

	// Read source; the store answers zero above its range, which also
	// covers unmapped offsets and window targets beyond the timer bank.
	wire [31:0] rdSel = tgtCtrl ? ctrlWord :
		tgtStat ? statWord : memBus.rdata;

	// Store port: the address is presented in the first cycle so the
	// registered read data are ready one cycle later.
	assign memBus.addr = stIdle ? tgtIdx : tgtReg;
	assign memBus.we = doneWr && tgtStore;
	assign memBus.be = avs_byteenable; // [RULE_05]
	assign memBus.wdata = avs_writedata;

	// Every access takes three cycles, which keeps the answer time fixed.
	always_comb begin
		case (stateReg)
			tdbw_pkg::ST_IDLE: stateNext = req ? tdbw_pkg::ST_FETCH :
				tdbw_pkg::ST_IDLE;
			tdbw_pkg::ST_FETCH: stateNext = tdbw_pkg::ST_DONE;
			tdbw_pkg::ST_DONE: stateNext = tdbw_pkg::ST_IDLE;
			default: stateNext = tdbw_pkg::ST_IDLE;
		endcase
	end

	// Burst control fields follow the byte lanes of a write.
	assign baseNext = (ctrlWr && avs_byteenable[0]) ?
		avs_writedata[tdbw_pkg::BASE_LSB +: 5] : baseReg; // [RULE_01]
	assign lenNext = (ctrlWr && avs_byteenable[1]) ?
		avs_writedata[tdbw_pkg::LEN_LSB +: 5] : lenReg; // [RULE_02]

	// Index steps once per window access, whatever the lane width, and
	// wraps after length plus one accesses.
	assign idxNext = ctrlWr ? tdbw_pkg::FIELD_RESET : // [RULE_07]
		!winDone ? idxReg :
		(idxReg >= lenReg) ? tdbw_pkg::FIELD_RESET : // [RULE_02] [RULE_07]
		idxReg + 5'h01; // [RULE_04] [RULE_05]

	// Sequencer and burst registers.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stateReg <= tdbw_pkg::ST_IDLE;
			baseReg <= tdbw_pkg::FIELD_RESET; // [RULE_06]
			lenReg <= tdbw_pkg::FIELD_RESET; // [RULE_06]
			idxReg <= tdbw_pkg::FIELD_RESET;
		end else begin
			stateReg <= stateNext;
			baseReg <= baseNext;
			lenReg <= lenNext;
			idxReg <= idxNext;
		end
	end

	// The target is frozen at the first cycle; the master holds its
	// request, but the index may not move under a pending access.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tgtReg <= 6'h00;
			winReg <= 1'b0;
		end else if (stIdle && req) begin
			tgtReg <= tgtIdx; // [RULE_03]
			winReg <= hitWin;
		end
	end

	// Read data are loaded in the middle cycle and held until the next.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			readDataReg <= tdbw_pkg::BURST_WINDOW_RESET;
		end else if (stFetch) begin
			readDataReg <= rdSel;
		end
	end

	assign avs_readdata = readDataReg;
	assign avs_waitrequest = !stDone;

	// Checks of the burst behaviour, all on the one clock domain.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_base_write;
		ctrlWr && avs_byteenable[0] |=>
			baseReg == $past(avs_writedata[4:0]);
	endproperty
	a_base_write: assert property (p_base_write) // [RULE_01]
		else $error("Base offset did not take the written value.");

	property p_len_wrap;
		winDone && idxReg == lenReg |=> idxReg == 5'h00;
	endproperty
	a_len_wrap: assert property (p_len_wrap) // [RULE_02]
		else $error("Index did not wrap after the last transfer.");

	property p_redirect;
		stIdle && req && hitWin |=> winReg &&
			tgtReg == $past({1'b0, baseReg}) + $past({1'b0, idxReg});
	endproperty
	a_redirect: assert property (p_redirect) // [RULE_03]
		else $error("Window access reached the wrong register.");

	property p_advance;
		winDone && idxReg != lenReg && !ctrlWr |=>
			idxReg == $past(idxReg) + 5'h01;
	endproperty
	a_advance: assert property (p_advance) // [RULE_04]
		else $error("Index did not advance after a window access.");

	property p_reset_zero;
		$past(!rst_n) |-> baseReg == 5'h00 && lenReg == 5'h00 &&
			idxReg == 5'h00 && readDataReg == 32'h0000_0000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) // [RULE_06]
		else $error("Burst registers not zero after reset.");

	property p_ctrl_clear;
		ctrlWr |=> idxReg == 5'h00 && stIdle;
	endproperty
	a_ctrl_clear: assert property (p_ctrl_clear) // [RULE_07]
		else $error("Control write did not restart the burst.");

	property p_answer_time;
		stIdle && req |-> avs_waitrequest ##2 !avs_waitrequest;
	endproperty
	a_answer_time: assert property (p_answer_time)
		else $error("Request not answered in three cycles.");

	property p_reserved_zero;
		stDone && tgtCtrl |-> avs_readdata[31:13] == 19'h00000 &&
			avs_readdata[7:5] == 3'b000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // [RULE_06]
		else $error("Reserved control bits read as nonzero.");

	// Field updates and holds of burst control and the burst index.
	property p_len_write;
		ctrlWr && avs_byteenable[1] |=>
			lenReg == $past(avs_writedata[12:8]);
	endproperty
	a_len_write: assert property (p_len_write) // [RULE_02]
		else $error("Burst length did not take the written value.");

	property p_base_hold;
		!(ctrlWr && avs_byteenable[0]) |=> $stable(baseReg);
	endproperty
	a_base_hold: assert property (p_base_hold) // [RULE_01]
		else $error("Base offset moved without a control write.");

	property p_len_hold;
		!(ctrlWr && avs_byteenable[1]) |=> $stable(lenReg);
	endproperty
	a_len_hold: assert property (p_len_hold) // [RULE_02]
		else $error("Burst length moved without a control write.");

	property p_idx_hold;
		!winDone && !ctrlWr |=> $stable(idxReg);
	endproperty
	a_idx_hold: assert property (p_idx_hold) // [RULE_04]
		else $error("Index moved without a window access.");

	// The index never passes the last transfer, because a shorter length
	// can only arrive with a control write, and that clears the index.
	property p_idx_range;
		idxReg <= lenReg;
	endproperty
	a_idx_range: assert property (p_idx_range) // [RULE_02]
		else $error("Index ran past the burst length.");

	// Target decode and store port behaviour during an access.
	property p_target_hold;
		stFetch |=> $stable(tgtReg) && $stable(winReg);
	endproperty
	a_target_hold: assert property (p_target_hold) // [RULE_03]
		else $error("Access target moved during the access.");

	property p_win_store_write;
		doneWr && winReg && tgtReg < tdbw_pkg::TIMER_WORDS |->
			memBus.we && memBus.addr == tgtReg;
	endproperty
	a_win_store_write: assert property (p_win_store_write) // [RULE_03]
		else $error("Window write missed its timer register.");

	property p_win_beyond;
		doneWr && winReg && tgtReg >= tdbw_pkg::TIMER_WORDS |-> !memBus.we;
	endproperty
	a_win_beyond: assert property (p_win_beyond) // [RULE_03]
		else $error("Window write past the bank reached the store.");

	property p_we_range;
		memBus.we |-> stDone && memBus.addr < tdbw_pkg::TIMER_WORDS;
	endproperty
	a_we_range: assert property (p_we_range) // [RULE_03]
		else $error("Store written outside an answer cycle or range.");

	property p_read_no_write;
		avs_read |-> !memBus.we;
	endproperty
	a_read_no_write: assert property (p_read_no_write)
		else $error("Read request wrote the timer store.");

	// Register images read back over the bus.
	property p_ctrl_read;
		stDone && tgtCtrl |-> avs_readdata[4:0] == baseReg &&
			avs_readdata[12:8] == lenReg;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) // [RULE_01] [RULE_02]
		else $error("Burst control read back the wrong fields.");

	property p_status_read;
		stDone && tgtStat |-> avs_readdata[4:0] == idxReg &&
			avs_readdata[31:5] == '0;
	endproperty
	a_status_read: assert property (p_status_read) // [RULE_04]
		else $error("Status did not show the burst index.");

	// Handshake shape of the register bus.
	property p_wait_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("Waitrequest stayed low for more than one cycle.");

	property p_rdata_hold;
		!stFetch |=> $stable(avs_readdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("Read data changed outside the load cycle.");

	property p_state_onehot;
		$onehot(stateReg);
	endproperty
	a_state_onehot: assert property (p_state_onehot)
		else $error("Sequencer state is not one-hot.");

	property p_sequence;
		stIdle && req |=> stFetch ##1 stDone ##1 stIdle;
	endproperty
	a_sequence: assert property (p_sequence)
		else $error("Access did not run idle, fetch, done, idle.");

	c_win_write: cover property (winDone && avs_write);
	c_win_read: cover property (winDone && avs_read && idxReg != 5'h00);
	c_wrap: cover property (winDone && idxReg == lenReg && lenReg != 5'h00);
	c_ctrl_write: cover property (ctrlWr);
	c_byte_window: cover property (winDone && avs_write &&
		avs_byteenable == 4'h1);

endmodule
